// [adc_result_format.v]
`include "adc_window_defines.vh"

// formats a 10-bit code into two result bytes
module adc_result_format (
   // conversion code
   input  wire [9:0] code,
   input  wire       leftJustify,
   input  wire       diffMode,
   // result bytes
   output reg  [7:0] highByte,
   output reg  [7:0] lowByte
);

   // right: sign-extend in differential, zero-fill otherwise; left: zero pad low
   always @* begin
      if (leftJustify) begin
         highByte = code[9:2];
         lowByte  = {code[1:0], 6'h00};
      end else begin
         highByte = diffMode ? {{6{code[9]}}, code[9:8]} : {6'h00, code[9:8]};
         lowByte  = code[7:0];
      end
   end

endmodule

// [adc_window_compare.v]
`include "adc_window_defines.vh"

// signed/unsigned window comparator on 16-bit register words
module adc_window_compare (
   // operands
   input  wire [15:0] result,
   input  wire [15:0] upperLim,
   input  wire [15:0] lowerLim,
   input  wire        diffMode,
   // match
   output wire        hit
);

   wire gtU;
   wire ltU;
   wire gtS;
   wire ltS;
   wire resAboveGt;
   wire resBelowLt;
   wire gtAboveLt;

   // the greater-than limit holds the lower edge when inside mode is chosen
   assign gtU = result > upperLim;
   assign ltU = result < lowerLim;
   assign gtS = $signed(result) > $signed(upperLim);
   assign ltS = $signed(result) < $signed(lowerLim);
   assign resAboveGt = diffMode ? gtS : gtU;
   assign resBelowLt = diffMode ? ltS : ltU;
   assign gtAboveLt  = diffMode ? ($signed(upperLim) > $signed(lowerLim))
                                : (upperLim > lowerLim);
   // inside: gt < r < lt; outside: r < lt or r > gt
   assign hit = gtAboveLt ? (resBelowLt || resAboveGt)
                          : (resAboveGt && resBelowLt);

endmodule

// [adc_window_control.v]
// Function
// - convert only while enable bit is one
// - enable zero holds shutdown, no conversions
// - positive select: pins, temperature, supply
// - negative select: pins, reference, ground
// - ground negative means single-ended, else differential
// - completion loads both result bytes
// - justification follows control bit zero
// - single-ended codes are unsigned ten bits
// - differential codes signed, signed window compare
// - window compared once per new result, flag set on match
// - flag readable by polling and interrupt source
// - upper and lower limits, byte pairs, writable
// - limit ordering alone picks inside or outside
// - inside: above greater-than and below less-than
// - outside: below lower or above upper bound
// - upper limit low resets all ones, RW
// - converter keeps running during debug halt
// - sequencing supports 200 ksps, ten bits
`include "adc_window_defines.vh"

module adc_window_control (
   // clock and reset
   input  wire       core_clk,
   input  wire       rst,
   // special function register port
   input  wire [7:0] sfrAddr,
   input  wire [7:0] sfrWdata,
   input  wire       sfrWrite,
   input  wire       sfrRead,
   output reg  [7:0] sfrRdata,
   // debug halt (ignored on purpose)
   input  wire       cpuHalted,
   // analog side
   output reg  [4:0] posChannel,
   output reg  [4:0] negChannel,
   output reg        converterPowerOn,
   output reg        trackHold,
   output reg        convStart,
   input  wire       convDone,
   input  wire [9:0] convCode,
   output reg        diffModeOut,
   // interrupt request
   output wire       windowIrq
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   // sequencer states and the conversion timeout
   localparam [1:0] ST_IDLE  = 2'b00;
   localparam [1:0] ST_TRACK = 2'b01;
   localparam [1:0] ST_CONV  = 2'b10;
   // full sample period, cut to the counter width on purpose
   localparam [31:0] CONV_FULL = `CONV_CYCLES;
   localparam [6:0]  CONV_LEN  = CONV_FULL[6:0];

   // register file, sequencer and result state
   reg [7:0] ctrl_q;
   reg [7:0] ctrl_d;
   reg [7:0] posSel_q;
   reg [7:0] negSel_q;
   reg [7:0] upLo_q;
   reg [7:0] upHi_q;
   reg [7:0] loLo_q;
   reg [7:0] loHi_q;
   reg [9:0] code_q;
   reg [7:0] resHi_q;
   reg [7:0] resLo_q;
   reg [1:0] state_q;
   reg [6:0] cnt_q;
   reg       fresh_q;
   reg       loadRes_q;
   reg [1:0] state_d;
   reg [6:0] cnt_d;
   reg [7:0] readMux;

   // decoded controls
   wire       enable;
   wire       enableNext;
   wire       diffMode;
   wire [7:0] fmtHi;
   wire [7:0] fmtLo;
   wire       winHit;
   wire       wrCtrl;
   wire       startReq;
   wire       sampleEnd;

   // control decode; the window flag doubles as the interrupt request
   assign enable   = ctrl_q[`CTRL_ENABLE];
   // enable as it stands after this edge, so a write that sets enable
   // and start together is taken instead of lost
   assign enableNext = wrCtrl ? sfrWdata[`CTRL_ENABLE] : enable;
   assign diffMode = (negSel_q != `NEG_SEL_GND);
   assign wrCtrl   = sfrWrite && (sfrAddr == `ADDR_CTRL);
   assign startReq = wrCtrl && sfrWdata[`CTRL_START];
   assign sampleEnd = (state_q == ST_CONV) && convDone;
   assign windowIrq = ctrl_q[`CTRL_WINFLAG];

   // ----------------------------------------
   // result formatting and window compare
   // ----------------------------------------
   // formatting follows the live justify bit; bytes latch only on a new result
   adc_result_format u_format (
      .code        (code_q),
      .leftJustify (ctrl_q[`CTRL_LJUST]),
      .diffMode    (diffMode),
      .highByte    (fmtHi),
      .lowByte     (fmtLo)
   );

   // limits are compared against the latched bytes, not the raw code
   adc_window_compare u_compare (
      .result   ({resHi_q, resLo_q}),
      .upperLim ({upHi_q, upLo_q}),
      .lowerLim ({loHi_q, loLo_q}),
      .diffMode (diffMode),
      .hit      (winHit)
   );

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // limit and selector registers; halt input deliberately not consulted
   // writes to unmapped addresses fall through the default and are lost
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         posSel_q <= `RST_SEL;
         negSel_q <= `RST_SEL;
         upLo_q   <= `RST_LIMIT_LO;
         upHi_q   <= `RST_LIMIT_HI;
         loLo_q   <= `RST_LOWER;
         loHi_q   <= `RST_LOWER;
      end else if (sfrWrite) begin
         case (sfrAddr)
            `ADDR_POS_SEL:  posSel_q <= sfrWdata;
            `ADDR_NEG_SEL:  negSel_q <= sfrWdata;
            `ADDR_UPPER_LO: upLo_q   <= sfrWdata;
            `ADDR_UPPER_HI: upHi_q   <= sfrWdata;
            `ADDR_LOWER_LO: loLo_q   <= sfrWdata;
            `ADDR_LOWER_HI: loHi_q   <= sfrWdata;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // control register and flags
   // ----------------------------------------
   // next control value; a hardware set wins over a software clear in the same cycle
   always @* begin
      ctrl_d = ctrl_q;
      if (wrCtrl) begin
         ctrl_d[`CTRL_ENABLE]  = sfrWdata[`CTRL_ENABLE];
         ctrl_d[`CTRL_LJUST]   = sfrWdata[`CTRL_LJUST];
         ctrl_d[2:1]           = sfrWdata[2:1];
         ctrl_d[`CTRL_WINFLAG] = sfrWdata[`CTRL_WINFLAG];
         ctrl_d[`CTRL_DONE]    = sfrWdata[`CTRL_DONE];
      end
      if (fresh_q && winHit) begin
         ctrl_d[`CTRL_WINFLAG] = 1'b1;
      end
      if (sampleEnd) begin
         ctrl_d[`CTRL_DONE] = 1'b1;
      end
      ctrl_d[`CTRL_START] = 1'b0;                                   // start reads back as zero
      ctrl_d[`CTRL_BUSY]  = (state_q != ST_IDLE);
   end

   // control register
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `RST_CTRL;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // ----------------------------------------
   // conversion sequencer
   // ----------------------------------------
   // next state; a clear of enable wins over everything, so shutdown is immediate
   always @* begin
      state_d = state_q;
      cnt_d   = cnt_q;
      if (!enableNext) begin
         state_d = ST_IDLE;
         cnt_d   = 7'd0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (startReq) begin
                  state_d = ST_TRACK;
                  cnt_d   = 7'd0;
               end
            end
            ST_TRACK: begin
               cnt_d = cnt_q + 7'd1;
               if (cnt_q == `TRACK_CYCLES - 7'd1) begin
                  state_d = ST_CONV;
               end
            end
            ST_CONV: begin
               cnt_d = cnt_q + 7'd1;
               if (convDone) begin
                  state_d = ST_IDLE;
               end else if (cnt_q >= CONV_LEN - 7'd1) begin
                  state_d = ST_IDLE;                                // watchdog if core never answers
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   // track then convert; total kept to one sample period of 100 cycles
   // a core slower than that is dropped by the watchdog, the old result kept
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q   <= 7'd0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // ----------------------------------------
   // result capture
   // ----------------------------------------
   // code taken with the done pulse, bytes loaded a cycle later once the
   // formatter sees the new code, window judged the cycle after that
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         code_q    <= 10'h000;
         loadRes_q <= 1'b0;
         resHi_q   <= 8'h00;
         resLo_q   <= 8'h00;
         fresh_q   <= 1'b0;
      end else begin
         loadRes_q <= sampleEnd;
         fresh_q   <= loadRes_q;
         if (sampleEnd) begin
            code_q <= convCode;
         end
         if (loadRes_q) begin
            resHi_q <= fmtHi;
            resLo_q <= fmtLo;
         end
      end
   end

   // ----------------------------------------
   // analog side drive
   // ----------------------------------------
   // the debug halt input is not used: converter runs through a halt
   // all drive is registered so the analog side never sees decode glitches
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         posChannel       <= 5'h00;
         negChannel       <= 5'h00;
         converterPowerOn <= 1'b0;
         trackHold        <= 1'b0;
         convStart        <= 1'b0;
         diffModeOut      <= 1'b0;
      end else begin
         posChannel       <= posSel_q[4:0];
         negChannel       <= negSel_q[4:0];
         converterPowerOn <= enable;
         trackHold        <= enable && (state_q == ST_TRACK);
         convStart        <= enable && (state_q == ST_TRACK) && (cnt_q == `TRACK_CYCLES - 7'd1);
         diffModeOut      <= diffMode;
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   // read select; unmapped addresses return zero
   always @* begin
      case (sfrAddr)
         `ADDR_CTRL:     readMux = ctrl_q;
         `ADDR_POS_SEL:  readMux = posSel_q;
         `ADDR_NEG_SEL:  readMux = negSel_q;
         `ADDR_RES_HIGH: readMux = resHi_q;
         `ADDR_RES_LOW:  readMux = resLo_q;
         `ADDR_UPPER_LO: readMux = upLo_q;
         `ADDR_UPPER_HI: readMux = upHi_q;
         `ADDR_LOWER_LO: readMux = loLo_q;
         `ADDR_LOWER_HI: readMux = loHi_q;
         default:        readMux = 8'h00;
      endcase
   end

   // registered read data, one cycle after address, held until the next read
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sfrRdata <= 8'h00;
      end else if (sfrRead) begin
         sfrRdata <= readMux;
      end
   end

endmodule

// [adc_window_control_assertions.sv]
`include "adc_window_defines.vh"
module adc_window_checker (
   // clock and reset
   input logic       core_clk,
   input logic       rst,
   // register port
   input logic [7:0] sfrAddr,
   input logic [7:0] sfrWdata,
   input logic       sfrWrite,
   input logic       sfrRead,
   input logic [7:0] sfrRdata,
   // analog side
   input logic [4:0] posChannel,
   input logic [4:0] negChannel,
   input logic       converterPowerOn,
   input logic       trackHold,
   input logic       convStart,
   input logic       convDone,
   input logic       diffModeOut,
   input logic       windowIrq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // tracking lasts long enough for the hold capacitor to settle
   sequence s_track;
      trackHold [*8] ##1 trackHold [*4];
   endsequence
   sequence s_gtl_wr;
      sfrWrite && sfrAddr == `ADDR_UPPER_LO ##2 sfrRead && sfrAddr == `ADDR_UPPER_LO;
   endsequence
   property p_track;
      $rose(trackHold) |-> s_track;
   endproperty
   property p_start;
      convStart |-> $past(trackHold, 8) && converterPowerOn ##1 !convStart;
   endproperty
   property p_off;
      !converterPowerOn && $past(!converterPowerOn) |-> !trackHold && !convStart;
   endproperty
   property p_en;
      sfrWrite && sfrAddr == `ADDR_CTRL |-> ##2 converterPowerOn == $past(sfrWdata[`CTRL_ENABLE], 2);
   endproperty
   property p_pos;
      sfrWrite && sfrAddr == `ADDR_POS_SEL |-> ##2 posChannel == $past(sfrWdata[4:0], 2);
   endproperty
   property p_neg;
      sfrWrite && sfrAddr == `ADDR_NEG_SEL |-> ##2 negChannel == $past(sfrWdata[4:0], 2);
   endproperty
   property p_mode;
      sfrWrite && sfrAddr == `ADDR_NEG_SEL |-> ##2 diffModeOut == ($past(sfrWdata, 2) != `NEG_SEL_GND);
   endproperty
   property p_flag;
      $rose(windowIrq) |-> $past(convDone, 3);
   endproperty
   // a flag only drops on a software write of zero, never by itself
   property p_hold;
      $fell(windowIrq) |-> $past(sfrWrite && sfrAddr == `ADDR_CTRL && !sfrWdata[`CTRL_WINFLAG]);
   endproperty
   property p_gtl;
      s_gtl_wr |=> sfrRdata == $past(sfrWdata, 3);
   endproperty
   a_track: assert property (p_track) else $error("tracking cut short");
   a_start: assert property (p_start) else $error("bad start pulse");
   a_off: assert property (p_off) else $error("activity while off");
   a_en: assert property (p_en) else $error("power not following enable");
   a_pos: assert property (p_pos) else $error("positive select wrong");
   a_neg: assert property (p_neg) else $error("negative select wrong");
   a_mode: assert property (p_mode) else $error("mode wrong");
   a_flag: assert property (p_flag) else $error("flag without result");
   a_hold: assert property (p_hold) else $error("flag dropped alone");
   a_gtl: assert property (p_gtl) else $error("limit readback wrong");
endmodule
bind adc_window_control adc_window_checker adc_window_checker_inst (.core_clk(core_clk), .rst(rst),
   .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
   .posChannel(posChannel), .negChannel(negChannel), .converterPowerOn(converterPowerOn),
   .trackHold(trackHold), .convStart(convStart), .convDone(convDone), .diffModeOut(diffModeOut),
   .windowIrq(windowIrq));

// [adc_window_defines.vh]
`ifndef ADC_WINDOW_DEFINES_VH
`define ADC_WINDOW_DEFINES_VH

// ----------------------------------------
// special function register addresses
// ----------------------------------------
`define ADDR_CTRL      8'he8
`define ADDR_POS_SEL   8'hbb
`define ADDR_NEG_SEL   8'hba
`define ADDR_RES_LOW   8'hbd
`define ADDR_RES_HIGH  8'hbe
`define ADDR_UPPER_LO  8'hc3
`define ADDR_UPPER_HI  8'hc4
`define ADDR_LOWER_LO  8'hc5
`define ADDR_LOWER_HI  8'hc6

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_ENABLE    7
`define CTRL_BUSY      4
`define CTRL_WINFLAG   3
`define CTRL_DONE      5
`define CTRL_START     6
`define CTRL_LJUST     0

// ----------------------------------------
// reset values and selector codes
// ----------------------------------------
`define RST_CTRL       8'h00
`define RST_SEL        8'h00
`define RST_LIMIT_LO   8'hff
`define RST_LIMIT_HI   8'hff
`define RST_LOWER      8'h00
`define NEG_SEL_GND    8'h1f
`define SEL_MAX_PIN    8'h12
`define POS_SEL_TEMP   8'h1e
`define POS_SEL_VDD    8'h1f
`define NEG_SEL_VREF   8'h1e

// ----------------------------------------
// timing: 20 MHz clock, 200 ksps => 100 cycles per sample
// ----------------------------------------
`define CLK_HZ         20000000
`define SAMPLE_RATE    200000
`define CONV_CYCLES    (`CLK_HZ / `SAMPLE_RATE)
`define TRACK_CYCLES   7'd20
`define CODE_BITS      10

`endif

// [conv_core_model.sv]
// ----------------------------------------
// converter core stand-in
// ----------------------------------------
module conv_core_model (
   // clock and reset
   input  logic       core_clk,
   input  logic       rst,
   // request and answer
   input  logic       convStart,
   input  logic [6:0] latency,
   input  logic [9:0] codeIn,
   output logic       convDone,
   output logic [9:0] convCode
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt;
   logic       busy;
   // answers latency+1 cycles after the start pulse; code toggles every cycle except the answer cycle so nothing stale is read
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         convDone <= 1'b0;
         cnt <= 8'h00;
         convCode <= 10'h155;
      end else begin
         convDone <= busy && cnt == 8'h00;
         convCode <= (busy && cnt == 8'h00) ? codeIn : ~convCode;
         if (convStart) begin
            busy <= 1'b1;
            cnt <= {1'b0, latency};
         end else if (busy && cnt == 8'h00)
            busy <= 1'b0;
         else
            cnt <= cnt - 8'h01;
      end
   end
endmodule

// [tb_top.sv]
`include "adc_window_defines.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       core_clk, rst, sfrWrite, sfrRead, cpuHalted, convDone, converterPowerOn;
   logic       trackHold, convStart, diffModeOut, windowIrq;
   logic [7:0] sfrAddr, sfrWdata, sfrRdata, d;
   logic [4:0] posChannel, negChannel;
   logic [9:0] convCode, codeIn;
   logic [9:0] corner [6] = '{10'h3ff, 10'h200, 10'h1ff, 10'h000, 10'h001, 10'h240};
   logic [6:0] latency;
   int         err_count, n_checks;
   adc_window_control adc_window_control_inst (.core_clk(core_clk), .rst(rst), .sfrAddr(sfrAddr),
      .sfrWdata(sfrWdata), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
      .cpuHalted(cpuHalted), .posChannel(posChannel), .negChannel(negChannel),
      .converterPowerOn(converterPowerOn), .trackHold(trackHold), .convStart(convStart),
      .convDone(convDone), .convCode(convCode), .diffModeOut(diffModeOut), .windowIrq(windowIrq));
   conv_core_model conv_core_model_inst (.core_clk(core_clk), .rst(rst), .convStart(convStart),
      .latency(latency), .codeIn(codeIn), .convDone(convDone), .convCode(convCode));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // strobes rise one negedge and fall the next, so two writes never share a time step
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge core_clk);
      sfrAddr = a;
      sfrWdata = v;
      sfrWrite = 1'b1;
      @(negedge core_clk);
      sfrWrite = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge core_clk);
      sfrAddr = a;
      sfrRead = 1'b1;
      @(negedge core_clk);
      sfrRead = 1'b0;
      @(negedge core_clk);
      v = sfrRdata;
   endtask
   task automatic quiet(input int n);
      logic t;
      t = 1'b0;
      repeat (n) begin
         @(negedge core_clk);
         t = t | trackHold | convStart;
      end
      chk(t, 1'b0);
   endtask
   function automatic logic [15:0] fmt(input logic [9:0] c, input logic lj, input logic dm);
      if (lj)
         return {c, 6'h00};
      return dm ? {{6{c[9]}}, c} : {6'h00, c};
   endfunction
   // seventeen bits so one signed compare serves both modes; equal limits select inside, never a match
   function automatic logic hit(input logic [15:0] r, gt, lt, input logic dm);
      logic signed [16:0] a, g, l;
      a = {dm & r[15], r};
      g = {dm & gt[15], gt};
      l = {dm & lt[15], lt};
      if (g > l)
         return a < l || a > g;
      return a > g && a < l;
   endfunction
   function automatic logic [7:0] pick();
      logic [7:0] p;
      p = 8'($urandom_range(20));
      return p > `SEL_MAX_PIN ? p + 8'h0b : p;
   endfunction
   task automatic conv(input logic [7:0] neg, input logic lj, input logic [9:0] c);
      logic [15:0] gt, lt, exp;
      logic [7:0]  hb;
      logic        dm;
      dm = neg != `NEG_SEL_GND;
      exp = fmt(c, lj, dm);
      gt = fmt(c + 10'($urandom_range(4)) - 10'h2, lj, dm);
      lt = fmt(c + 10'($urandom_range(4)) - 10'h2, lj, dm);
      codeIn = c;
      latency = 7'($urandom_range(70));
      cpuHalted = 1'($urandom);
      wr(`ADDR_NEG_SEL, neg);
      wr(`ADDR_POS_SEL, pick());
      wr(`ADDR_UPPER_LO, gt[7:0]);
      wr(`ADDR_UPPER_HI, gt[15:8]);
      wr(`ADDR_LOWER_LO, lt[7:0]);
      wr(`ADDR_LOWER_HI, lt[15:8]);
      wr(`ADDR_CTRL, {7'h60, lj});
      d = 8'h00;
      for (int i = 0; i < 60 && !d[`CTRL_DONE]; i++)
         rd(`ADDR_CTRL, d);
      chk(d[`CTRL_DONE], 1'b1);
      rd(`ADDR_RES_HIGH, hb);
      rd(`ADDR_RES_LOW, d);
      chk({hb, d}, exp);
      rd(`ADDR_CTRL, d);
      chk(d[`CTRL_WINFLAG], hit(exp, gt, lt, dm));
      chk(windowIrq, hit(exp, gt, lt, dm));
      wr(`ADDR_CTRL, {7'h40, lj});
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      err_count++;
      print_verdict();
   end
   initial begin
      {sfrAddr, sfrWdata, sfrWrite, sfrRead, cpuHalted, latency, codeIn} = '0;
      err_count = 0;
      n_checks = 0;
      rst = 1'b1;
      void'($urandom(32'h92ebcf62));
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      rd(`ADDR_UPPER_LO, d);
      chk(d, `RST_LIMIT_LO);
      rd(`ADDR_LOWER_HI, d);
      chk(d, `RST_LOWER);
      wr(`ADDR_UPPER_LO, 8'h5a);
      rd(`ADDR_UPPER_LO, d);
      chk(d, 8'h5a);
      wr(8'h00, 8'h77);
      rd(8'h00, d);
      chk(d, 8'h00);
      $display("register test done");
      wr(`ADDR_CTRL, 8'h40);
      quiet(30);
      wr(`ADDR_CTRL, 8'hc0);
      repeat (15) @(negedge core_clk);
      chk(trackHold, 1'b1);
      wr(`ADDR_CTRL, 8'h00);
      quiet(40);
      chk(converterPowerOn, 1'b0);
      $display("enable test done");
      for (int i = 0; i < 6; i++)
         conv(i % 3 == 0 ? `NEG_SEL_GND : (i % 3 == 1 ? `NEG_SEL_VREF : 8'h05), 1'(i), corner[i]);
      repeat (14) conv(pick(), 1'($urandom), 10'($urandom));
      $display("conversion test done");
      print_verdict();
   end
endmodule
